// [verilog/incdec_alu_pkg.sv]
// Package: opcode, field and timing constants for the inc/dec and literal execution unit
package incdec_alu_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;
  localparam int OPSEL_W = 3;

  // ----------------------------------------------------------------
  // Operation select codes from the decoder
  // ----------------------------------------------------------------
  localparam logic [OPSEL_W-1:0] OP_DECREMENT_FILE       = 3'h0;
  localparam logic [OPSEL_W-1:0] OP_INCREMENT_FILE       = 3'h1;
  localparam logic [OPSEL_W-1:0] OP_DECREMENT_SKIP       = 3'h2;
  localparam logic [OPSEL_W-1:0] OP_INCREMENT_SKIP       = 3'h3;
  localparam logic [OPSEL_W-1:0] OP_OR_LITERAL           = 3'h4;
  localparam logic [OPSEL_W-1:0] OP_LOAD_LITERAL         = 3'h5;

  // ----------------------------------------------------------------
  // Destination bit values, reset values, timing
  // ----------------------------------------------------------------
  localparam logic       DEST_ACCUMULATOR = 1'b0;
  localparam logic       DEST_FILE        = 1'b1;
  localparam logic [7:0] ACC_RESET        = 8'h00;
  localparam logic       NULL_RESET       = 1'b0;
  localparam logic [7:0] ONE              = 8'h01;
  localparam int         SKIP_CYCLES      = 2;   // instruction_cycle count of a taken skip
endpackage : incdec_alu_pkg

// [verilog/incdec_literal_alu_ops.sv]
// Execution unit for inc/dec file, skip-on-null variants, OR literal and load literal
// Summary of operation
// RULE1: decrement_file subtracts one from the file operand, writes it to the accumulator (d=0) or file (d=1) and updates the null flag.
// RULE2: increment_file adds one to the file operand, routes it by the destination bit and updates the null flag.
// RULE3: decrement_skip_on_null stores the decremented value by destination, leaves flags alone and on a zero result turns the next instruction into a no-operation (two cycles).
// RULE4: increment_skip_on_null stores the incremented value by destination, leaves flags alone and on a zero result turns the next instruction into a no-operation (two cycles).
// RULE5: or_literal_into_accumulator ORs the 8-bit literal into the accumulator and updates the null flag.
// RULE6: load_literal places the 8-bit literal in the accumulator with no flag change.
// RULE7: the encoder of load_literal fills its don't-care opcode bits with zeros.
// RULE8: each instruction finishes in one instruction cycle unless a skip is taken.
`timescale 1ns/1ns
`default_nettype none
module incdec_literal_alu_ops
  import incdec_alu_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic               instrValid,   // One decoded instruction per cycle
  input  wire logic [OPSEL_W-1:0] opSelect,
  input  wire logic               destBit,
  input  wire logic [ADDR_W-1:0]  fileAddr,
  input  wire logic [DATA_W-1:0]  fileData,     // Read data of the addressed file register
  input  wire logic [DATA_W-1:0]  literal,
  output var  logic [DATA_W-1:0]  accumulator,
  output var  logic               resultNull,
  output var  logic               fileWrEn,
  output var  logic [ADDR_W-1:0]  fileWrAddr,
  output var  logic [DATA_W-1:0]  fileWrData,
  output logic                    instrBusy     // High during the discarded slot, whose instruction is not executed
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic isFileOp(input logic [OPSEL_W-1:0] op);
    return (op == OP_DECREMENT_FILE) || (op == OP_INCREMENT_FILE) ||
           (op == OP_DECREMENT_SKIP) || (op == OP_INCREMENT_SKIP);
  endfunction : isFileOp

  function automatic logic isSkipOp(input logic [OPSEL_W-1:0] op);
    return (op == OP_DECREMENT_SKIP) || (op == OP_INCREMENT_SKIP);
  endfunction : isSkipOp

  typedef enum logic {EXEC, SKIP_SLOT} exec_state_t;

  logic [DATA_W-1:0] aluResult;
  logic              accepted;
  logic              skipTaken;
  exec_state_t       state_reg;
  exec_state_t       state_next;

  // ----------------------------------------------------------------
  // Combinational datapath
  // ----------------------------------------------------------------
  // A slot squashed by a skip is treated as a no-operation, never executed
  assign accepted = instrValid && (state_reg == EXEC);

  always_comb begin
    unique case (opSelect)
      OP_DECREMENT_FILE, OP_DECREMENT_SKIP: aluResult = fileData - ONE;        // RULE1 RULE3
      OP_INCREMENT_FILE, OP_INCREMENT_SKIP: aluResult = fileData + ONE;        // RULE2 RULE4
      OP_OR_LITERAL:                        aluResult = accumulator | literal; // RULE5
      OP_LOAD_LITERAL:                      aluResult = literal;               // RULE6
      default:                              aluResult = accumulator;
    endcase
  end

  assign skipTaken = accepted && isSkipOp(opSelect) && (aluResult == 8'h00);   // RULE3 RULE4

  // ----------------------------------------------------------------
  // Skip sequencing
  // ----------------------------------------------------------------
  // Two-cycle skip: execute slot, then one no-operation slot
  always_comb begin
    unique case (state_reg)
      EXEC:      state_next = skipTaken ? SKIP_SLOT : EXEC;                    // RULE8
      SKIP_SLOT: state_next = EXEC;
    endcase
  end

  // State register; reset drops a pending discarded slot so the first instruction after release is taken
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg <= EXEC;
    end else begin
      state_reg <= state_next;
    end
  end

  assign instrBusy = (state_reg == SKIP_SLOT);

  // ----------------------------------------------------------------
  // Accumulator update
  // ----------------------------------------------------------------
  // Literal ops always land here; file ops only when the destination bit selects the accumulator
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      accumulator <= ACC_RESET;
    end else if (accepted) begin
      if (opSelect == OP_OR_LITERAL || opSelect == OP_LOAD_LITERAL) begin
        accumulator <= aluResult;                                              // RULE5 RULE6
      end else if (isFileOp(opSelect) && destBit == DEST_ACCUMULATOR) begin
        accumulator <= aluResult;                                              // RULE1 RULE2
      end
    end
  end

  // ----------------------------------------------------------------
  // File write-back
  // ----------------------------------------------------------------
  // Registered so the data file sees a clean one-cycle write strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fileWrEn   <= 1'b0;
      fileWrAddr <= '0;
      fileWrData <= 8'h00;
    end else begin
      fileWrEn <= accepted && isFileOp(opSelect) && (destBit == DEST_FILE);   // RULE1 RULE2
      if (accepted && isFileOp(opSelect)) begin
        fileWrAddr <= fileAddr;
        fileWrData <= aluResult;
      end
    end
  end

  // ----------------------------------------------------------------
  // Null flag: skip variants and load literal leave it alone
  // ----------------------------------------------------------------
  // Flag follows the result whichever destination it went to
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      resultNull <= NULL_RESET;
    end else if (accepted && (opSelect == OP_DECREMENT_FILE || opSelect == OP_INCREMENT_FILE ||
                              opSelect == OP_OR_LITERAL)) begin
      resultNull <= (aluResult == 8'h00);                                      // RULE1 RULE2 RULE5
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_skipIssued;
    accepted && isSkipOp(opSelect) && aluResult == 8'h00;
  endsequence

  sequence s_noopSlot;
    instrBusy ##1 !instrBusy;
  endsequence

  a_dec_to_acc: assert property (@(posedge sys_clk) disable iff (reset) // RULE1
    accepted && opSelect == OP_DECREMENT_FILE && destBit == DEST_ACCUMULATOR
    |=> accumulator == $past(fileData) - ONE && resultNull == (accumulator == 8'h00))
    else $error("decrement to accumulator wrong");

  a_inc_to_file: assert property (@(posedge sys_clk) disable iff (reset) // RULE2
    accepted && opSelect == OP_INCREMENT_FILE && destBit == DEST_FILE
    |=> fileWrEn && fileWrData == $past(fileData) + ONE && accumulator == $past(accumulator))
    else $error("increment to file wrong");

  a_skip_two_cycles: assert property (@(posedge sys_clk) disable iff (reset) // RULE3
    s_skipIssued |=> s_noopSlot)
    else $error("skip did not take exactly two cycles");

  a_skip_flag_hold: assert property (@(posedge sys_clk) disable iff (reset) // RULE4
    accepted && isSkipOp(opSelect) |=> $stable(resultNull))
    else $error("skip variant changed null flag");

  a_or_literal: assert property (@(posedge sys_clk) disable iff (reset) // RULE5
    accepted && opSelect == OP_OR_LITERAL
    |=> accumulator == ($past(accumulator) | $past(literal)) && resultNull == (accumulator == 8'h00))
    else $error("or literal wrong");

  a_load_literal: assert property (@(posedge sys_clk) disable iff (reset) // RULE6
    accepted && opSelect == OP_LOAD_LITERAL |=> accumulator == $past(literal) && $stable(resultNull))
    else $error("load literal wrong");

  a_single_cycle: assert property (@(posedge sys_clk) disable iff (reset) // RULE8
    accepted && !skipTaken |=> !instrBusy)
    else $error("non-skip instruction stalled");

  a_squash_noop: assert property (@(posedge sys_clk) disable iff (reset) // RULE3
    instrBusy |=> $stable(accumulator) && !fileWrEn)
    else $error("squashed slot had an effect");

  // Destination routing of the other plain cases and of one destination per skip variant, and the discarded slot
  a_dec_to_file: assert property (@(posedge sys_clk) disable iff (reset) // RULE1
    accepted && opSelect == OP_DECREMENT_FILE && destBit == DEST_FILE
    |=> fileWrEn && fileWrData == $past(fileData) - ONE && fileWrAddr == $past(fileAddr) &&
        $stable(accumulator) && resultNull == (fileWrData == 8'h00))
    else $error("decrement to file wrong");

  a_inc_to_acc: assert property (@(posedge sys_clk) disable iff (reset) // RULE2
    accepted && opSelect == OP_INCREMENT_FILE && destBit == DEST_ACCUMULATOR
    |=> accumulator == $past(fileData) + ONE && !fileWrEn && resultNull == (accumulator == 8'h00))
    else $error("increment to accumulator wrong");

  a_dec_skip_acc: assert property (@(posedge sys_clk) disable iff (reset) // RULE3
    accepted && opSelect == OP_DECREMENT_SKIP && destBit == DEST_ACCUMULATOR
    |=> accumulator == $past(fileData) - ONE && !fileWrEn && $stable(resultNull))
    else $error("decrement skip to accumulator wrong");

  a_inc_skip_file: assert property (@(posedge sys_clk) disable iff (reset) // RULE4
    accepted && opSelect == OP_INCREMENT_SKIP && destBit == DEST_FILE
    |=> fileWrEn && fileWrData == $past(fileData) + ONE && fileWrAddr == $past(fileAddr) && $stable(accumulator))
    else $error("increment skip to file wrong");

  a_skip_not_taken: assert property (@(posedge sys_clk) disable iff (reset) // RULE4
    accepted && isSkipOp(opSelect) && aluResult != 8'h00 |=> !instrBusy)
    else $error("skip taken on a non-zero result");

  a_busy_one_slot: assert property (@(posedge sys_clk) disable iff (reset) // RULE8
    instrBusy |=> !instrBusy)
    else $error("discarded slot lasted more than one cycle");

  a_squash_flag: assert property (@(posedge sys_clk) disable iff (reset) // RULE3
    instrBusy |=> $stable(resultNull))
    else $error("discarded slot changed the null flag");

  a_literal_no_write: assert property (@(posedge sys_clk) disable iff (reset) // RULE6
    accepted && (opSelect == OP_OR_LITERAL || opSelect == OP_LOAD_LITERAL) |=> !fileWrEn)
    else $error("literal instruction wrote the file");

endmodule : incdec_literal_alu_ops
`default_nettype wire

// [sim/incdec_literal_alu_ops_tb.sv]
// Self-checking testbench for the inc/dec and literal execution unit
`timescale 1ns/1ns
`default_nettype none
module incdec_literal_alu_ops_tb;
  import incdec_alu_pkg::*;
  logic               sys_clk = 1'b0;
  logic               reset = 1'b1;
  logic               instrValid = 1'b0;
  logic [OPSEL_W-1:0] opSelect = 3'h0;
  logic               destBit = 1'b0;
  logic [ADDR_W-1:0]  fileAddr = 7'h00;
  logic [DATA_W-1:0]  fileData = 8'h00;
  logic [DATA_W-1:0]  literal = 8'h00;
  logic [DATA_W-1:0]  accumulator, fileWrData;
  logic [ADDR_W-1:0]  fileWrAddr;
  logic               resultNull, fileWrEn, instrBusy;
  int                 n_mismatch = 0;
  int                 checks_done = 0;

  always #2 sys_clk = ~sys_clk;  // 250 MHz

  incdec_literal_alu_ops uut (.sys_clk(sys_clk), .reset(reset), .instrValid(instrValid), .opSelect(opSelect),
    .destBit(destBit), .fileAddr(fileAddr), .fileData(fileData), .literal(literal), .accumulator(accumulator),
    .resultNull(resultNull), .fileWrEn(fileWrEn), .fileWrAddr(fileWrAddr), .fileWrData(fileWrData),
    .instrBusy(instrBusy));

  // ----------------------------------------------------------------
  // Compare helpers
  // ----------------------------------------------------------------
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask : chk1

  // One instruction at the next edge; inputs move 1 ns after the edge, outputs read there too
  task automatic exec(input logic [2:0] op, input logic d, input logic [6:0] a, input logic [7:0] fd,
                      input logic [7:0] lit);
    instrValid = 1'b1;
    opSelect   = op;
    destBit    = d;
    fileAddr   = a;
    fileData   = fd;
    literal    = lit;
    @(posedge sys_clk);
    #1;
  endtask : exec

  // An empty cycle: an instruction on the bus without the valid strobe must change nothing
  task automatic idle;
    instrValid = 1'b0;
    opSelect   = OP_LOAD_LITERAL;
    literal    = 8'hA5;
    @(posedge sys_clk);
    #1;
  endtask : idle

  // Expected accumulator, flag, write pulse with its data, and discarded-slot marker
  task automatic res(input logic [7:0] acc, input logic nul, input logic w, input logic [7:0] wd, input logic b);
    chk8("accumulator", acc, accumulator);
    chk1("resultNull", nul, resultNull);
    chk1("fileWrEn", w, fileWrEn);
    if (w) chk8("fileWrData", wd, fileWrData);
    if (w) chk8("fileWrAddr", {1'b0, fileAddr}, {1'b0, fileWrAddr});
    chk1("instrBusy", b, instrBusy);
  endtask : res

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    res(ACC_RESET, NULL_RESET, 1'b0, 8'h00, 1'b0);
  endtask : t_reset

  // Wrap at both ends, both destinations; a write must not touch the accumulator
  task automatic t_incdec;
    exec(OP_LOAD_LITERAL, 1'b0, 7'h00, 8'h00, 8'h5A);
    res(8'h5A, 1'b0, 1'b0, 8'h00, 1'b0);
    exec(OP_DECREMENT_FILE, DEST_ACCUMULATOR, 7'h10, 8'h01, 8'h00);
    res(8'h00, 1'b1, 1'b0, 8'h00, 1'b0);
    exec(OP_DECREMENT_FILE, DEST_FILE, 7'h7F, 8'h00, 8'h00);
    res(8'h00, 1'b0, 1'b1, 8'hFF, 1'b0);
    exec(OP_INCREMENT_FILE, DEST_ACCUMULATOR, 7'h05, 8'hFF, 8'h00);
    res(8'h00, 1'b1, 1'b0, 8'h00, 1'b0);
    exec(OP_INCREMENT_FILE, DEST_FILE, 7'h01, 8'h7F, 8'h00);
    res(8'h00, 1'b0, 1'b1, 8'h80, 1'b0);
  endtask : t_incdec

  // Taken skips discard a back-to-back instruction; flags stay as they were
  task automatic t_skip;
    exec(OP_DECREMENT_SKIP, DEST_FILE, 7'h22, 8'h01, 8'h00);
    res(8'h00, 1'b0, 1'b1, 8'h00, 1'b1);
    exec(OP_LOAD_LITERAL, 1'b0, 7'h00, 8'h00, 8'h77);
    res(8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
    exec(OP_INCREMENT_SKIP, DEST_ACCUMULATOR, 7'h33, 8'hFF, 8'h00);
    res(8'h00, 1'b0, 1'b0, 8'h00, 1'b1);
    exec(OP_OR_LITERAL, 1'b0, 7'h00, 8'h00, 8'h81);
    res(8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
    exec(OP_INCREMENT_SKIP, DEST_ACCUMULATOR, 7'h33, 8'h05, 8'h00);
    res(8'h06, 1'b0, 1'b0, 8'h00, 1'b0);
    exec(OP_DECREMENT_SKIP, DEST_FILE, 7'h44, 8'h05, 8'h00);
    res(8'h06, 1'b0, 1'b1, 8'h04, 1'b0);
    exec(OP_DECREMENT_FILE, DEST_ACCUMULATOR, 7'h10, 8'h01, 8'h00);
    res(8'h00, 1'b1, 1'b0, 8'h00, 1'b0);
    exec(OP_INCREMENT_SKIP, DEST_ACCUMULATOR, 7'h33, 8'h04, 8'h00);
    res(8'h05, 1'b1, 1'b0, 8'h00, 1'b0);
  endtask : t_skip

  // Literal ops, zero-filled literals, and an unused code that must do nothing
  task automatic t_literal;
    exec(OP_OR_LITERAL, 1'b0, 7'h00, 8'h00, 8'h00);
    res(8'h05, 1'b0, 1'b0, 8'h00, 1'b0);
    exec(OP_LOAD_LITERAL, 1'b0, 7'h00, 8'h00, 8'h00);
    res(8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
    exec(OP_OR_LITERAL, 1'b0, 7'h00, 8'h00, 8'h00);
    res(8'h00, 1'b1, 1'b0, 8'h00, 1'b0);
    exec(OP_LOAD_LITERAL, 1'b0, 7'h00, 8'h00, 8'h3C);
    res(8'h3C, 1'b1, 1'b0, 8'h00, 1'b0);
    exec(OP_OR_LITERAL, 1'b0, 7'h00, 8'h00, 8'hC3);
    res(8'hFF, 1'b0, 1'b0, 8'h00, 1'b0);
    exec(3'h6, DEST_FILE, 7'h01, 8'h00, 8'h00);
    res(8'hFF, 1'b0, 1'b0, 8'h00, 1'b0);
  endtask : t_literal

  // Reset in the middle of a discarded slot, work at the first edge after release, then an empty cycle
  task automatic t_reset_mid;
    exec(OP_INCREMENT_SKIP, DEST_FILE, 7'h12, 8'hFF, 8'h00);
    res(8'hFF, 1'b0, 1'b1, 8'h00, 1'b1);
    reset = 1'b1;
    exec(OP_DECREMENT_SKIP, DEST_ACCUMULATOR, 7'h01, 8'h01, 8'h00);
    reset = 1'b0;
    t_reset();
    exec(OP_LOAD_LITERAL, 1'b0, 7'h00, 8'h00, 8'h99);
    res(8'h99, 1'b0, 1'b0, 8'h00, 1'b0);
    exec(OP_DECREMENT_SKIP, DEST_ACCUMULATOR, 7'h01, 8'h01, 8'h00);
    res(8'h00, 1'b0, 1'b0, 8'h00, 1'b1);
    exec(OP_LOAD_LITERAL, 1'b0, 7'h00, 8'h00, 8'h99);
    res(8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
    idle();
    res(8'h00, 1'b0, 1'b0, 8'h00, 1'b0);
  endtask : t_reset_mid

  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("mismatches %0d of %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_incdec();
    t_skip();
    t_literal();
    t_reset_mid();
    give_verdict();
  end
endmodule : incdec_literal_alu_ops_tb
`default_nettype wire
